// *** hw/mcr_init_ctrl.sv ***
// mode latching, configuration latches, write protection and memory map control
`timescale 1ns/1ns
// Notes on behaviour
// - mode pins sampled at reset give boot, special and expanded bits per table.
// - expanded bit clear means single chip or bootstrap, ports active.
// - normal modes: protected bits written only once and only in first 64 cycles; special overrides.
// - config bits 7, 6, 1 read one; others come from nonvolatile cells.
// - behaviour follows latches; reads show latches; normal writes go to nonvolatile byte.
// - config reads show value loaded at last reset; new value needs another reset.
// - special mode writes config latches directly; otherwise only programming, next reset.
// - config bit 5 drives divided clock onto clock output pin, else pin held low.
// - config bit 4 lets pull-up assignments through, else all pull-ups off.
// - config bit 3 set disables memory security, clear enables it.
// - config bit 2 set disables watchdog, clear enables it.
// - config bit 0 set puts nonvolatile data memory into the map.
// - map register resets to zero; normal modes allow one write in 64 cycles.
// - map upper nibble picks the 4K page where the 768-byte RAM starts.
// - map lower nibble picks the 4K page of the 160-byte register block.
// - on a shared page registers win and RAM moves right after them.
// - after the load phase mode pins no longer change the mode.
// - special bit once cleared cannot be set again until reset.
// - mode bits writable by software only while special bit is set.
module mcr_init_ctrl
	import mcr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [9:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic mode_pin_a,
	input wire logic mode_pin_b,
	input wire logic [7:0] nvm_config_cells,
	output logic nvm_program_strobe,
	output logic [7:0] nvm_program_data,
	input wire logic divided_clock_signal,
	input wire logic [7:0] pullup_assignment_reg,
	input wire logic [15:0] cpu_addr,
	output logic boot_rom_select,
	output logic special_mode_flag,
	output logic expanded_bus_flag,
	output logic ports_active,
	output logic init_done,
	output logic clock_out_enable,
	output logic clock_output_pin,
	output logic pullup_gate_enable,
	output logic [7:0] pullup_enable,
	output logic security_disable,
	output logic watchdog_disable,
	output logic nvm_map_enable,
	output logic [7:0] map_value,
	output logic reg_block_hit,
	output logic ram_hit,
	output logic [9:0] ram_offset
);

	typedef struct packed {
		mcr_phase_t phase;
		logic [1:0] settle;
		logic [2:0] sync_a;
		logic [2:0] sync_b;
		logic [6:0] win_cnt;
		logic map_written;
		mcr_mode_t mode;
		logic [7:0] map;
		logic [7:0] cfg;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic prog_strobe;
		logic [7:0] prog_data;
		logic clk_pin;
		logic [7:0] pullups;
		logic ports_active;
		logic init_done;
		mcr_map_hit_t hit;
	} mcr_state_t;

	// the configuration latch starts at its ones pattern; the load phase fills the rest
	localparam mcr_state_t STATE_RESET = '{
		phase: MCR_SETTLE,
		settle: 2'h0,
		sync_a: 3'h0,
		sync_b: 3'h0,
		win_cnt: 7'h00,
		map_written: 1'b0,
		mode: '{boot: 1'b0, special: 1'b0, expanded: 1'b0},
		map: MAP_RESET,
		cfg: CFG_RESET,
		prdata: 32'h0000_0000,
		pready: 1'b0,
		pslverr: 1'b0,
		prog_strobe: 1'b0,
		prog_data: 8'h00,
		clk_pin: 1'b0,
		pullups: 8'h00,
		ports_active: 1'b0,
		init_done: 1'b0,
		hit: '{reg_hit: 1'b0, ram_hit: 1'b0, ram_offset: 10'h000}
	};

	mcr_state_t s;
	mcr_state_t next_s;
	mcr_map_hit_t dec_hit;

	function automatic logic [1:0] mcr_reg_select(input logic [9:0] addr);
		logic [1:0] sel;
		if (addr == ADDR_MODE) begin
			sel = 2'd1;
		end else if (addr == ADDR_MAP) begin
			sel = 2'd2;
		end else if (addr == ADDR_CFG) begin
			sel = 2'd3;
		end else begin
			sel = 2'd0;
		end
		return sel;
	endfunction : mcr_reg_select

	function automatic logic [7:0] mcr_mode_byte(input mcr_mode_t m);
		logic [7:0] b;
		b = 8'h00;
		b[MODE_BOOT_BIT] = m.boot;
		b[MODE_SPECIAL_BIT] = m.special;
		b[MODE_EXPANDED_BIT] = m.expanded;
		return b;
	endfunction : mcr_mode_byte

	// a pin counts as settled once the second and third stages agree
	function automatic logic mcr_sync_agrees(input logic [2:0] sync);
		return sync[2] == sync[1];
	endfunction : mcr_sync_agrees

	function automatic logic [2:0] mcr_sync_shift(input logic [2:0] sync, input logic pin);
		return {sync[1:0], pin};
	endfunction : mcr_sync_shift

	// unimplemented bits are forced so software always reads them as one
	function automatic logic [7:0] mcr_cfg_latch(input logic [7:0] raw, input logic [7:0] keep);
		return (raw & keep) | CFG_ONES_MASK;
	endfunction : mcr_cfg_latch

	function automatic logic [31:0] mcr_word(input logic [7:0] b);
		return {24'h000000, b};
	endfunction : mcr_word

	function automatic logic [31:0] mcr_read_value(input logic [1:0] sel, input mcr_mode_t m,
		input logic [7:0] map, input logic [7:0] cfg);
		logic [31:0] v;
		if (sel == 2'd1) begin
			v = mcr_word(mcr_mode_byte(m));
		end else if (sel == 2'd2) begin
			v = mcr_word(map);
		end else if (sel == 2'd3) begin
			v = mcr_word(cfg);
		end else begin
			v = 32'h0000_0000;
		end
		return v;
	endfunction : mcr_read_value

	// the special bit can only fall; a one in the data never raises it again
	function automatic mcr_mode_t mcr_mode_write(input mcr_mode_t m, input logic [7:0] d);
		mcr_mode_t r;
		r.boot = d[MODE_BOOT_BIT];
		r.special = d[MODE_SPECIAL_BIT] & m.special;
		r.expanded = d[MODE_EXPANDED_BIT];
		return r;
	endfunction : mcr_mode_write

	// a window alone would let a second write through; the written flag closes that gap
	function automatic logic mcr_map_write_ok(input mcr_mode_t m, input logic written,
		input logic open_win);
		return m.special || (!written && open_win);
	endfunction : mcr_map_write_ok

	mcr_map_decode u_map_decode (
		.cpu_addr(cpu_addr),
		.map_value(s.map),
		.hit(dec_hit)
	);

	logic [1:0] sel;
	logic access;
	logic complete;
	logic window_open;
	logic settled;
	logic wr_byte;

	always_comb begin
		next_s = s;
		sel = mcr_reg_select(paddr);
		access = psel && penable && !s.pready;
		complete = psel && penable && s.pready;
		window_open = (s.win_cnt < PROT_WINDOW_COUNT);
		settled = mcr_sync_agrees(s.sync_a) && mcr_sync_agrees(s.sync_b);
		// only the low byte lane carries a register; a write without it changes nothing
		wr_byte = complete && pwrite && pstrb[0];

		next_s.sync_a = mcr_sync_shift(s.sync_a, mode_pin_a);
		next_s.sync_b = mcr_sync_shift(s.sync_b, mode_pin_b);
		// the count stops at the window edge, so it can never wrap and reopen it
		if (window_open) begin
			next_s.win_cnt = 7'(s.win_cnt + 7'h01);
		end
		next_s.pready = 1'b0;
		next_s.pslverr = 1'b0;
		next_s.prog_strobe = 1'b0;

		case (s.phase)
			MCR_SETTLE: begin
				// wait until the synchronised pins stop moving before trusting them
				if (s.settle != SETTLE_CYCLES) begin
					next_s.settle = 2'(s.settle + 2'h1);
				end else if (settled) begin
					next_s.phase = MCR_LOAD;
				end
			end
			MCR_LOAD: begin
				next_s.mode = mcr_mode_from_pins(s.sync_b[2], s.sync_a[2]);
				next_s.cfg = mcr_cfg_latch(nvm_config_cells, 8'hFF);
				next_s.phase = MCR_RUN;
			end
			MCR_RUN: begin
				// register answers wait for the load so reads never see stale latches
				if (access) begin
					next_s.pready = 1'b1;
					next_s.pslverr = (sel == 2'd0);
					next_s.prdata = mcr_read_value(sel, s.mode, s.map, s.cfg);
				end
				if (wr_byte) begin
					if (sel == 2'd1) begin
						if (s.mode.special) begin
							next_s.mode = mcr_mode_write(s.mode, pwdata[7:0]);
						end
					end else if (sel == 2'd2) begin
						if (mcr_map_write_ok(s.mode, s.map_written, window_open)) begin
							next_s.map = pwdata[7:0];
							next_s.map_written = 1'b1;
						end
						// otherwise ignored
					end else if (sel == 2'd3) begin
						if (s.mode.special) begin
							next_s.cfg = mcr_cfg_latch(pwdata[7:0], CFG_WRITE_MASK);
						end else begin
							// latches stay put; the byte goes to the programming path
							next_s.prog_strobe = 1'b1;
							next_s.prog_data = pwdata[7:0];
						end
					end
				end
			end
			default: begin
				next_s.phase = MCR_SETTLE;
			end
		endcase

		// kept as its own flop so the output never shows a phase decode
		next_s.init_done = (next_s.phase == MCR_RUN);
		// derived outputs are registered, so each lags its source by one cycle
		next_s.ports_active = !s.mode.expanded;
		next_s.clk_pin = s.cfg[CFG_CLKOUT_BIT] & divided_clock_signal;
		next_s.pullups = s.cfg[CFG_PULLUP_BIT] ? pullup_assignment_reg : 8'h00;
		next_s.hit = dec_hit;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= STATE_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign nvm_program_strobe = s.prog_strobe;
	assign nvm_program_data = s.prog_data;
	assign boot_rom_select = s.mode.boot;
	assign special_mode_flag = s.mode.special;
	assign expanded_bus_flag = s.mode.expanded;
	assign ports_active = s.ports_active;
	assign init_done = s.init_done;
	assign clock_out_enable = s.cfg[CFG_CLKOUT_BIT];
	assign clock_output_pin = s.clk_pin;
	assign pullup_gate_enable = s.cfg[CFG_PULLUP_BIT];
	assign pullup_enable = s.pullups;
	assign security_disable = s.cfg[CFG_SECURITY_BIT];
	assign watchdog_disable = s.cfg[CFG_WATCHDOG_BIT];
	assign nvm_map_enable = s.cfg[CFG_NVM_BIT];
	assign map_value = s.map;
	assign reg_block_hit = s.hit.reg_hit;
	assign ram_hit = s.hit.ram_hit;
	assign ram_offset = s.hit.ram_offset;

endmodule : mcr_init_ctrl

// *** shared/mcr_pkg.sv ***
// package of constants and types for the mode, configuration and memory map block
package mcr_pkg;

	// register indices; the byte address on the bus is four times the index
	localparam logic [7:0] IDX_MODE = 8'h3C;
	localparam logic [7:0] IDX_MAP = 8'h3D;
	localparam logic [7:0] IDX_CFG = 8'h3F;
	localparam logic [9:0] ADDR_MODE = {IDX_MODE, 2'b00};
	localparam logic [9:0] ADDR_MAP = {IDX_MAP, 2'b00};
	localparam logic [9:0] ADDR_CFG = {IDX_CFG, 2'b00};

	// mode register fields
	localparam int unsigned MODE_BOOT_BIT = 7;
	localparam int unsigned MODE_SPECIAL_BIT = 6;
	localparam int unsigned MODE_EXPANDED_BIT = 5;

	// configuration register fields
	localparam int unsigned CFG_CLKOUT_BIT = 5;
	localparam int unsigned CFG_PULLUP_BIT = 4;
	localparam int unsigned CFG_SECURITY_BIT = 3;
	localparam int unsigned CFG_WATCHDOG_BIT = 2;
	localparam int unsigned CFG_NVM_BIT = 0;
	localparam logic [7:0] CFG_ONES_MASK = 8'hC2;
	localparam logic [7:0] CFG_WRITE_MASK = 8'h3D;
	localparam logic [7:0] CFG_RESET = 8'hC2;

	// map register fields and reset
	localparam logic [7:0] MAP_RESET = 8'h00;
	localparam int unsigned MAP_RAM_MSB = 7;
	localparam int unsigned MAP_RAM_LSB = 4;
	localparam int unsigned MAP_REG_MSB = 3;
	localparam int unsigned MAP_REG_LSB = 0;

	// timing, counted in bus clocks from reset release
	localparam int unsigned PROT_WINDOW_CYCLES = 64;
	localparam logic [6:0] PROT_WINDOW_COUNT = 7'(PROT_WINDOW_CYCLES);
	localparam logic [1:0] SETTLE_CYCLES = 2'h3;

	// memory map geometry
	localparam logic [11:0] REG_BLOCK_BYTES = 12'h0A0;
	localparam logic [11:0] RAM_BYTES = 12'h300;

	typedef struct packed {
		logic boot;
		logic special;
		logic expanded;
	} mcr_mode_t;

	typedef enum logic [1:0] {
		MCR_SETTLE = 2'b00,
		MCR_LOAD = 2'b01,
		MCR_RUN = 2'b10
	} mcr_phase_t;

	typedef struct packed {
		logic reg_hit;
		logic ram_hit;
		logic [9:0] ram_offset;
	} mcr_map_hit_t;

	function automatic mcr_mode_t mcr_mode_from_pins(input logic pin_b, input logic pin_a);
		mcr_mode_t m;
		case ({pin_b, pin_a})
			2'b10: m = '{boot: 1'b0, special: 1'b0, expanded: 1'b0};
			2'b11: m = '{boot: 1'b0, special: 1'b0, expanded: 1'b1};
			2'b00: m = '{boot: 1'b1, special: 1'b1, expanded: 1'b0};
			default: m = '{boot: 1'b0, special: 1'b1, expanded: 1'b1};
		endcase
		return m;
	endfunction : mcr_mode_from_pins

endpackage : mcr_pkg

// *** hw/mcr_map_decode.sv ***
// address decode of the internal register block and the RAM for one core address
`timescale 1ns/1ns
module mcr_map_decode
	import mcr_pkg::*;
(
	input wire logic [15:0] cpu_addr,
	input wire logic [7:0] map_value,
	output mcr_map_hit_t hit
);

	logic [3:0] reg_page;
	logic [3:0] ram_page;
	logic [11:0] page_off;
	logic [11:0] ram_base;
	logic [11:0] ram_end;
	logic in_reg_page;
	logic in_ram_page;

	always_comb begin
		reg_page = map_value[MAP_REG_MSB:MAP_REG_LSB];
		ram_page = map_value[MAP_RAM_MSB:MAP_RAM_LSB];
		page_off = cpu_addr[11:0];
		in_reg_page = (cpu_addr[15:12] == reg_page);
		in_ram_page = (cpu_addr[15:12] == ram_page);
		// sharing a page pushes the RAM past the register block so none of it is hidden
		ram_base = (ram_page == reg_page) ? REG_BLOCK_BYTES : 12'h000;
		ram_end = 12'(ram_base + RAM_BYTES);
		hit.reg_hit = in_reg_page && (page_off < REG_BLOCK_BYTES);
		hit.ram_hit = !hit.reg_hit && in_ram_page && (page_off >= ram_base)
			&& (page_off < ram_end);
		hit.ram_offset = 10'(page_off - ram_base);
	end

endmodule : mcr_map_decode

// *** verification/mcr_init_ctrl_monitor.sv ***
// concurrent checks on the ports of the mode, configuration and map block
`timescale 1ns/1ns
module mcr_init_ctrl_monitor
	import mcr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic divided_clock_signal,
	input wire logic nvm_program_strobe,
	input wire logic boot_rom_select,
	input wire logic special_mode_flag,
	input wire logic expanded_bus_flag,
	input wire logic ports_active,
	input wire logic init_done,
	input wire logic clock_out_enable,
	input wire logic clock_output_pin,
	input wire logic [7:0] map_value
);
	logic [6:0] cyc;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_wait;
		psel && penable && !pready;
	endsequence
	// edges since release, saturating; the map write window shuts once it reaches 64
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cyc <= '0;
		end else if (cyc != 7'h7F) begin
			cyc <= cyc + 7'h01;
		end
	end
	chk_pready_pulse: assert property (pready |=> !pready) else $error("pready held");
	chk_err_pair: assert property (pslverr |-> pready) else $error("pslverr alone");
	chk_answer_bound: assert property (s_wait |-> ##[1:20] pready) else $error("no pready");
	chk_ports_active: assert property (init_done |=>
		ports_active == !$past(expanded_bus_flag)) else $error("ports_active wrong");
	chk_clkout_gate: assert property (init_done |=>
		clock_output_pin == ($past(clock_out_enable) && $past(divided_clock_signal)))
		else $error("clock output wrong");
	chk_special_sticky: assert property (init_done && !special_mode_flag |=>
		!special_mode_flag) else $error("special mode set again");
	chk_mode_locked: assert property (init_done && !special_mode_flag |=>
		$stable(boot_rom_select) && $stable(expanded_bus_flag)) else $error("mode changed");
	chk_map_locked: assert property (init_done && !special_mode_flag && cyc >= 7'h40 |=>
		$stable(map_value)) else $error("map changed late");
	chk_prog_pulse: assert property (nvm_program_strobe |=> !nvm_program_strobe)
		else $error("program strobe held");
	chk_prog_normal: assert property (nvm_program_strobe |-> !special_mode_flag)
		else $error("program strobe in special mode");
endmodule : mcr_init_ctrl_monitor

// *** verification/mcr_pin_model.sv ***
// far side: board straps on the mode pins and the nonvolatile configuration byte
`timescale 1ns/1ns
module mcr_pin_model
	import mcr_pkg::*;
#(parameter logic [7:0] CELLS_INIT = 8'h19)
(
	input wire logic pclk,
	input wire logic [1:0] strap,
	input wire logic nvm_program_strobe,
	input wire logic [7:0] nvm_program_data,
	output logic mode_pin_a,
	output logic mode_pin_b,
	output logic [7:0] nvm_config_cells
);
	// the cells survive reset, so a programmed byte shows only after the next one
	logic [7:0] cells = CELLS_INIT;
	assign {mode_pin_b, mode_pin_a} = strap;
	assign nvm_config_cells = cells;
	always @(posedge pclk) begin
		if (nvm_program_strobe) begin
			cells <= nvm_program_data;
		end
	end
endmodule : mcr_pin_model

// *** verification/mcr_init_ctrl_tb.sv ***
// self-checking bench for the mode, configuration and map block
`timescale 1ns/1ns
module mcr_init_ctrl_tb;
	import mcr_pkg::*;
	// boot, special, expanded for pins {b,a} = 11, 10, 01, 00
	localparam logic [11:0] MODES = 12'h21E;
	logic pclk = '0, presetn = '0, psel = '0, penable = '0, pwrite = '0;
	logic divided_clock_signal = '0, rerr;
	logic [9:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rdat;
	logic [3:0] pstrb = 4'hF;
	logic [7:0] pullup_assignment_reg = 8'h5A;
	logic [15:0] cpu_addr = '0;
	logic [1:0] strap = 2'h2;
	logic pready, pslverr, mode_pin_a, mode_pin_b, nvm_program_strobe, boot_rom_select;
	logic special_mode_flag, expanded_bus_flag, ports_active, init_done, clock_out_enable;
	logic clock_output_pin, pullup_gate_enable, security_disable, watchdog_disable;
	logic nvm_map_enable, reg_block_hit, ram_hit;
	logic [7:0] nvm_config_cells, nvm_program_data, pullup_enable, map_value;
	logic [9:0] ram_offset;
	wire [4:0] cfg_bits = {clock_out_enable, pullup_gate_enable, security_disable,
		watchdog_disable, nvm_map_enable};
	wire [2:0] mode_bits = {boot_rom_select, special_mode_flag, expanded_bus_flag};
	int bad_count = 0, checked = 0, cyc = 0;
	mcr_init_ctrl mcr_init_ctrl_i (.*);
	mcr_pin_model #(.CELLS_INIT(8'h19)) mcr_pin_model_i (.pclk, .strap, .nvm_program_strobe,
		.nvm_program_data, .mode_pin_a, .mode_pin_b, .nvm_config_cells);
	always #4 pclk = ~pclk;
	// the whole run needs well under a thousand cycles
	always @(posedge pclk) begin
		divided_clock_signal <= ~divided_clock_signal;
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			final_report();
		end
	end
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic apb(input logic wr, input logic [9:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= '1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= '1;
		// no wait limit here: the cycle ceiling of the bench ends a hung transfer
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= '0;
		penable <= '0;
	endtask : apb
	task automatic do_reset(input logic [1:0] s);
		@(posedge pclk);
		presetn <= '0;
		strap <= s;
		repeat (3) @(posedge pclk);
		presetn <= '1;
		repeat (20) begin
			@(posedge pclk);
			if (init_done === 1'b1) break;
		end
		chk("init", init_done, 1'b1);
	endtask : do_reset
	task automatic dec(input logic [15:0] a, input logic [11:0] e);
		@(posedge pclk);
		cpu_addr <= a;
		repeat (2) @(posedge pclk);
		chk("decode", {reg_block_hit, ram_hit, ram_hit ? ram_offset : 10'h0}, e);
	endtask : dec
	task automatic t_modes();
		for (int i = 0; i < 4; i++) begin
			do_reset(2'(i));
			strap <= ~strap;
			repeat (6) @(posedge pclk);
			chk("mode", mode_bits, MODES[3*i+:3]);
			chk("ports", ports_active, !MODES[3*i]);
		end
		$display("done: mode pins");
	endtask : t_modes
	task automatic t_normal();
		do_reset(2'h2);
		apb('0, ADDR_CFG, '0);
		chk("cfg", rdat, 32'hDB);
		chk("cfg_bits", cfg_bits, 5'h0D);
		apb('1, ADDR_CFG, 8'hE6);
		apb('0, ADDR_CFG, '0);
		chk("cfg_kept", rdat, 32'hDB);
		chk("prog_data", nvm_program_data, 8'hE6);
		apb('1, ADDR_MODE, 8'hE0);
		apb('1, ADDR_MAP, 8'h21);
		apb('1, ADDR_MAP, 8'h43);
		apb('0, ADDR_MAP, '0);
		chk("map_once", rdat, 32'h21);
		apb('0, ADDR_MODE, '0);
		chk("mode_ro", rdat, 32'h0);
		apb('0, 10'h100, '0);
		chk("unmapped", rerr, 1'b1);
		do_reset(2'h2);
		apb('0, ADDR_CFG, '0);
		chk("cfg_new", rdat, 32'hE6);
		repeat (64) @(posedge pclk);
		apb('1, ADDR_MAP, 8'h55);
		apb('0, ADDR_MAP, '0);
		chk("map_late", rdat, 32'h0);
		$display("done: normal mode");
	endtask : t_normal
	task automatic t_special();
		do_reset(2'h0);
		apb('1, ADDR_CFG, 8'h31);
		apb('0, ADDR_CFG, '0);
		chk("cfg_sp", rdat, 32'hF3);
		chk("cfg_bits", cfg_bits, 5'h19);
		chk("pullups", pullup_enable, 8'h5A);
		apb('1, ADDR_CFG, 8'h00);
		repeat (2) @(posedge pclk);
		chk("pullups_off", pullup_enable, 8'h00);
		apb('1, ADDR_MAP, 8'h12);
		apb('1, ADDR_MAP, 8'h11);
		dec(16'h1050, 12'h800);
		dec(16'h10A5, 12'h405);
		dec(16'h139F, 12'h6FF);
		apb('1, ADDR_MAP, 8'h21);
		pstrb <= 4'hE;
		apb('1, ADDR_MAP, 8'h77);
		pstrb <= 4'hF;
		apb('0, ADDR_MAP, '0);
		chk("map_strb", rdat, 32'h21);
		dec(16'h22FF, 12'h6FF);
		dec(16'h2300, 12'h000);
		apb('1, ADDR_MODE, 8'h20);
		apb('1, ADDR_MODE, 8'hE0);
		apb('0, ADDR_MODE, '0);
		chk("mode_sp", rdat, 32'h20);
		$display("done: special mode");
	endtask : t_special
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report
	initial begin
		t_modes();
		t_normal();
		t_special();
		final_report();
	end
endmodule : mcr_init_ctrl_tb
bind mcr_init_ctrl mcr_init_ctrl_monitor mcr_init_ctrl_monitor_i (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
	.divided_clock_signal(divided_clock_signal), .nvm_program_strobe(nvm_program_strobe),
	.boot_rom_select(boot_rom_select), .special_mode_flag(special_mode_flag),
	.expanded_bus_flag(expanded_bus_flag), .ports_active(ports_active), .init_done(init_done),
	.clock_out_enable(clock_out_enable), .clock_output_pin(clock_output_pin),
	.map_value(map_value));
